// file: src/hrl_consts.vh
// Constants shared by the headroom tracking limiter files.
`ifndef HRL_CONSTS_VH
`define HRL_CONSTS_VH
`define HRL_ADDR_CTRL     8'h00
`define HRL_ADDR_MPO      8'h04
`define HRL_ADDR_STATUS   8'h08
`define HRL_ADDR_LIMIT    8'h0c
`define HRL_ADDR_SUPPLY   8'h10
`define HRL_CTRL_TYPE     0
`define HRL_CTRL_ROT_LSB  4
`define HRL_CTRL_THR_LSB  8
`define HRL_CTRL_HR_LSB   12
`define HRL_CTRL_RESET    32'h00000000
`define HRL_MPO_RESET     12'hfff
`define HRL_UNITY         16'h8000
`define HRL_PCT_STEPS     6'h28
`define HRL_DIV_STEPS     6'h22
`define HRL_FIFO_DEPTH    16
`define HRL_FIFO_AW       4
`endif

// file: src/hrl_gain_rom.v
// Lookup of linear gain for 0 dB to -15 dB in 1 dB steps, registered read.
`timescale 1ns/1ns
module hrl_gain_rom (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [3:0]  addr,
  output reg  [15:0] data
);
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      data <= 16'h8000;
    else
    begin
      case (addr)
        4'h0: data <= 16'h8000;
        4'h1: data <= 16'h7215;
        4'h2: data <= 16'h65ad;
        4'h3: data <= 16'h5a9e;
        4'h4: data <= 16'h50c3;
        4'h5: data <= 16'h47fb;
        4'h6: data <= 16'h4027;
        4'h7: data <= 16'h392d;
        4'h8: data <= 16'h32f5;
        4'h9: data <= 16'h2d6b;
        4'ha: data <= 16'h287a;
        4'hb: data <= 16'h2413;
        4'hc: data <= 16'h2027;
        4'hd: data <= 16'h1ca8;
        4'he: data <= 16'h198a;
        default: data <= 16'h16c3;
      endcase
    end
  end
endmodule // hrl_gain_rom

// file: src/hrl_fifo.v
// Sample FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module hrl_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            push;
  wire            pop;

  assign level     = wr_ptr - rd_ptr;
  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // hrl_fifo

// file: src/hrl_limiter.v
// Headroom tracking limiter: supply tracking and fixed level limiting.
`timescale 1ns/1ns
`include "hrl_consts.vh"
// How it works
// - Type select low with rotation point zero selects supply tracking limiting.
// - Tracking limiter clamps peaks at the computed target peak output level.
// - Tracking knee equals threshold, the target over maximum peak ratio.
// - Below the knee samples pass; above it the output peak equals the knee.
// - Knee is recomputed from current supply and settings for every sample.
// - Target above maximum peak output gives no tracking attenuation at all.
// - Type select high with rotation point zero selects fixed level limiting.
// - Fixed threshold spans 0 dB to -15 dB and is the knee.
// - Fixed output limit is maximum peak output times the threshold gain.
// - Below fixed threshold samples pass; above it output peak equals threshold.
// - Fixed threshold ignores the supply; its transfer never changes with it.
// - Target peak output is supply scaled by one minus headroom percent.
// - Target ratio is clamped to unity, so no positive gain ever.
// - Measured supply follows whichever rail currently powers the amplifier.
module hrl_limiter (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [11:0] pvdd_level,
  input  wire [11:0] vbat_level,
  input  wire        rail_is_pvdd,
  input  wire [15:0] sample_in,
  input  wire        sample_in_valid,
  output wire        sample_in_ready,
  output reg  [15:0] sample_out,
  output reg         sample_out_valid,
  input  wire        sample_out_ready,
  output reg         limiting
);
  localparam S_IDLE  = 5'b00001;
  localparam S_RATIO = 5'b00010;
  localparam S_KNEE  = 5'b00100;
  localparam S_GAIN  = 5'b01000;
  localparam S_MUL   = 5'b10000;

  reg  [31:0] ctrl;
  reg  [11:0] maximum_peak_output;
  reg  [4:0]  state;
  reg  [15:0] sample;
  reg  [16:0] sample_abs;
  reg  [15:0] target_peak_ratio;
  reg  [15:0] gain;
  reg  [33:0] div_num;
  reg  [17:0] div_den;
  reg  [18:0] div_rem;
  reg  [33:0] div_q;
  reg  [5:0]  div_cnt;

  wire        limiter_type_select;
  wire [3:0]  compressor_rotation_point;
  wire [3:0]  fixed_limit_threshold;
  wire [4:0]  supply_headroom;
  wire [11:0] measured_supply;
  wire [5:0]  headroom_scale;
  wire [17:0] target_peak_x40;
  wire [17:0] maximum_peak_x40;
  wire [15:0] fixed_threshold_level;
  wire [27:0] fixed_output_prod;
  wire [11:0] fixed_output_limit;
  wire [15:0] tracking_knee;
  wire [15:0] knee;
  wire [15:0] fifo_data;
  wire        fifo_valid;
  wire        fifo_ready;
  wire [4:0]  fifo_level;
  wire [18:0] rem_shift;
  wire        rem_ge;
  wire [18:0] rem_sub;
  wire [32:0] product;
  wire [16:0] in_abs;

  assign limiter_type_select       = ctrl[`HRL_CTRL_TYPE];
  assign compressor_rotation_point = ctrl[`HRL_CTRL_ROT_LSB+3:`HRL_CTRL_ROT_LSB];
  assign fixed_limit_threshold     = ctrl[`HRL_CTRL_THR_LSB+3:`HRL_CTRL_THR_LSB];
  assign supply_headroom           = ctrl[`HRL_CTRL_HR_LSB+4:`HRL_CTRL_HR_LSB];

  // The active rail decides which conversion result feeds the tracker.
  assign measured_supply = rail_is_pvdd ? pvdd_level : vbat_level;

  // Headroom is signed in 2.5 % steps, so 100 % is forty steps.
  assign headroom_scale = `HRL_PCT_STEPS -
                          {supply_headroom[4], supply_headroom};
  assign target_peak_x40 = measured_supply * headroom_scale;
  assign maximum_peak_x40 = maximum_peak_output * `HRL_PCT_STEPS;

  hrl_gain_rom u_rom (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .addr    (fixed_limit_threshold),
    .data    (fixed_threshold_level)
  );

  assign fixed_output_prod  = maximum_peak_output * fixed_threshold_level;
  assign fixed_output_limit = fixed_output_prod[26:15];

  assign tracking_knee = target_peak_ratio;

  // Rotation points other than 0 dBFS belong to the compressor modes,
  // which this stage does not implement, so it passes audio unchanged.
  assign knee = (compressor_rotation_point != 4'h0) ? `HRL_UNITY :
                limiter_type_select ? fixed_threshold_level :
                tracking_knee;

  hrl_fifo #(
    .WIDTH (16),
    .DEPTH (`HRL_FIFO_DEPTH),
    .AW    (`HRL_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   (sample_in),
    .in_valid  (sample_in_valid),
    .in_ready  (sample_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .level     (fifo_level)
  );

  // A sample is taken only when the output register is free.
  assign fifo_ready = (state == S_IDLE) && !sample_out_valid;

  assign in_abs = fifo_data[15] ? (17'h00000 - {fifo_data[15], fifo_data})
                                : {1'b0, fifo_data};

  // Restoring long division, one quotient bit per clock.
  assign rem_shift = {div_rem[17:0], div_num[33]};
  assign rem_ge    = (rem_shift >= {1'b0, div_den});
  assign rem_sub   = rem_shift - {1'b0, div_den};

  assign product = $signed(sample) * $signed({1'b0, gain});

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state             <= S_IDLE;
      sample            <= 16'h0000;
      sample_abs        <= 17'h00000;
      target_peak_ratio <= `HRL_UNITY;
      gain              <= `HRL_UNITY;
      div_num           <= 34'h000000000;
      div_den           <= 18'h00000;
      div_rem           <= 19'h00000;
      div_q             <= 34'h000000000;
      div_cnt           <= 6'h00;
      sample_out        <= 16'h0000;
      sample_out_valid  <= 1'b0;
      limiting          <= 1'b0;
    end
    else
    begin
      if (sample_out_valid && sample_out_ready)
        sample_out_valid <= 1'b0;
      if (div_cnt != 6'h00)
      begin
        div_num <= {div_num[32:0], 1'b0};
        div_rem <= rem_ge ? rem_sub : rem_shift;
        div_q   <= {div_q[32:0], rem_ge};
        div_cnt <= div_cnt - 6'h01;
      end
      case (state)
        S_IDLE:
        begin
          if (fifo_valid && fifo_ready)
          begin
            sample     <= fifo_data;
            sample_abs <= in_abs;
            // Ratio of target to maximum peak, taken fresh per sample.
            div_num <= {1'b0, target_peak_x40, 15'h0000};
            div_den <= maximum_peak_x40;
            div_rem <= 19'h00000;
            div_q   <= 34'h000000000;
            div_cnt <= `HRL_DIV_STEPS;
            state   <= S_RATIO;
          end
        end
        S_RATIO:
        begin
          if (div_cnt == 6'h00)
          begin
            // Any ratio above unity, or a zero maximum, means no cut.
            if (div_q > {18'h00000, `HRL_UNITY})
              target_peak_ratio <= `HRL_UNITY;
            else
              target_peak_ratio <= div_q[15:0];
            state <= S_KNEE;
          end
        end
        S_KNEE:
        begin
          if (sample_abs > {1'b0, knee})
          begin
            // Gain that brings the peak down to the knee.
            div_num <= {3'h0, knee, 15'h0000};
            div_den <= {1'b0, sample_abs};
            div_rem <= 19'h00000;
            div_q   <= 34'h000000000;
            div_cnt <= `HRL_DIV_STEPS;
            state   <= S_GAIN;
          end
          else
          begin
            gain  <= `HRL_UNITY;
            state <= S_MUL;
          end
        end
        S_GAIN:
        begin
          if (div_cnt == 6'h00)
          begin
            gain  <= div_q[15:0];
            state <= S_MUL;
          end
        end
        S_MUL:
        begin
          sample_out       <= product[30:15];
          sample_out_valid <= 1'b1;
          limiting         <= (gain != `HRL_UNITY);
          state            <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl                <= `HRL_CTRL_RESET;
      maximum_peak_output <= `HRL_MPO_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `HRL_ADDR_CTRL)
        ctrl <= {15'h0000, reg_wdata[16:8], reg_wdata[7:4],
                 3'h0, reg_wdata[0]};
      else if (reg_addr == `HRL_ADDR_MPO)
        maximum_peak_output <= reg_wdata[11:0];
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      if (reg_addr == `HRL_ADDR_CTRL)
        reg_rdata <= {15'h0000, ctrl[16:4], 3'h0, ctrl[0]};
      else if (reg_addr == `HRL_ADDR_MPO)
        reg_rdata <= {20'h00000, maximum_peak_output};
      else if (reg_addr == `HRL_ADDR_STATUS)
        reg_rdata <= {10'h000, fifo_level, limiting, target_peak_ratio};
      else if (reg_addr == `HRL_ADDR_LIMIT)
        reg_rdata <= {4'h0, fixed_threshold_level, fixed_output_limit};
      else if (reg_addr == `HRL_ADDR_SUPPLY)
        reg_rdata <= {2'h0, target_peak_x40, measured_supply};
      else
        reg_rdata <= 32'h00000000;
    end
  end
endmodule // hrl_limiter

// file: verification/hrl_far_model.sv
// Far side model: supply measurements and output sample sink.
`timescale 1ns/1ns
module hrl_far_model (
  input  wire        clk_sys,
  input  wire [15:0] sample_out,
  input  wire        sample_out_valid,
  output reg         sample_out_ready = 1'b0,
  output reg  [11:0] pvdd_level = 12'hfff,
  output reg  [11:0] vbat_level = 12'hfff,
  output reg         rail_is_pvdd = 1'b1
);
  reg [15:0] got [$];
  reg        stall = 1'b0;
  always @(posedge clk_sys)
  begin
    sample_out_ready <= !stall;
    if (sample_out_valid && sample_out_ready)
      got.push_back(sample_out);
  end
  // The powering rail flag tells the limiter which level to use.
  task set_rails(input [11:0] pv, input [11:0] vb, input on_pv);
  begin
    pvdd_level <= pv;
    vbat_level <= vb;
    rail_is_pvdd <= on_pv;
  end
  endtask
endmodule // hrl_far_model

// file: verification/hrl_chk.sv
// Assertions on the limiter's register and sample ports.
`timescale 1ns/1ns
module hrl_chk (
  input wire        clk_sys,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        sample_in_ready,
  input wire [15:0] sample_out,
  input wire        sample_out_valid,
  input wire        sample_out_ready,
  input wire        limiting
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reg [3:0] rot;
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      rot <= 4'h0;
    else if (reg_wr && reg_addr == 8'h00)
      rot <= reg_wdata[7:4];
  a_ctrl_readback: assert property (reg_wr && reg_addr == 8'h00 ##1
    reg_rd && reg_addr == 8'h00 |=>
    reg_rdata[16:0] == $past(reg_wdata[16:0], 2)) else $error("ctrl back");
  a_mpo_readback: assert property (reg_wr && reg_addr == 8'h04 ##1
    reg_rd && reg_addr == 8'h04 |=>
    reg_rdata[11:0] == $past(reg_wdata[11:0], 2)) else $error("mpo back");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_out_held: assert property (sample_out_valid && !sample_out_ready
    |=> sample_out_valid && $stable(sample_out)) else $error("out dropped");
  a_taken_only: assert property ($fell(sample_out_valid)
    |-> $past(sample_out_ready)) else $error("valid fell untaken");
  a_reset_idle: assert property ($rose(rst_n)
    |-> sample_in_ready && !sample_out_valid && !limiting)
    else $error("not idle after reset");
  a_flag_with_out: assert property ($changed(limiting)
    |-> $rose(sample_out_valid)) else $error("flag moved alone");
  a_bypass_clear: assert property ($rose(sample_out_valid) && rot != 4'h0
    |-> !limiting) else $error("limit in bypass");
  cover property ($rose(limiting));
  cover property ($fell(sample_in_ready));
  cover property (sample_out_valid && !sample_out_ready);
endmodule // hrl_chk
bind hrl_limiter hrl_chk i_chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .sample_in_ready, .sample_out,
  .sample_out_valid, .sample_out_ready, .limiting);

// file: verification/tb_top.sv
// Self-checking bench of the headroom tracking limiter.
`timescale 1ns/1ns
module tb_top;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [15:0] sample_in = 16'h0;
  reg         sample_in_valid = 1'b0;
  wire [31:0] reg_rdata;
  wire [11:0] pvdd_level;
  wire [11:0] vbat_level;
  wire        rail_is_pvdd;
  wire        sample_in_ready;
  wire [15:0] sample_out;
  wire        sample_out_valid;
  wire        sample_out_ready;
  wire        limiting;
  integer     fails = 0;
  integer     check_count = 0;
  integer     i;
  integer     n;
  integer     g;
  integer     e;
  reg         r;
  reg  [31:0] d;
  reg  [15:0] s;
  initial
    forever #2 clk_sys = ~clk_sys;
  hrl_limiter i_hrl_limiter (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pvdd_level, .vbat_level, .rail_is_pvdd,
    .sample_in, .sample_in_valid, .sample_in_ready, .sample_out,
    .sample_out_valid, .sample_out_ready, .limiting);
  hrl_far_model i_hrl_far_model (.clk_sys, .sample_out, .sample_out_valid,
    .sample_out_ready, .pvdd_level, .vbat_level, .rail_is_pvdd);
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] exp, input [31:0] got, input [8*8:1] what);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // Bus tasks are entered and left in the time step of a rising edge.
  task wr(input [7:0] a, input [31:0] v);
  begin
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  end
  endtask
  task get;
    integer w;
  begin
    for (w = 0; w < 300 && i_hrl_far_model.got.size() == 0; w = w + 1)
      @(negedge clk_sys);
    if (w == 300)
    begin
      fails = fails + 1;
      complete_run;
    end
    s = i_hrl_far_model.got.pop_front();
    @(posedge clk_sys);
  end
  endtask
  task send(input [15:0] x);
  begin
    sample_in <= x;
    sample_in_valid <= 1'b1;
    @(posedge clk_sys);
    sample_in_valid <= 1'b0;
    get;
  end
  endtask
  function [15:0] lim(input integer x, input integer k);
  begin
    lim = x;
    if (x > k || -x > k)
      lim = (x * ((k * 32768) / (x < 0 ? -x : x))) >>> 15;
  end
  endfunction
  task t_mode1;
  begin
    wr(8'h04, 32'h800);
    rd(8'h04);
    chk(32'h800, d[11:0], "mpo");
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk(32'h0, d, "ctrl");
    i_hrl_far_model.set_rails(12'h400, 12'hfff, 1'b1);
    send(16'h3000);
    chk(16'h3000, s, "below");
    chk(1'b0, limiting, "flag");
    send(16'h6000);
    chk(lim($signed(16'h6000), 32'h4000), s, "above");
    chk(1'b1, limiting, "flag");
    send(16'ha000);
    chk(lim($signed(16'ha000), 32'h4000), s, "negative");
    rd(8'h08);
    chk(16'h4000, d[15:0], "ratio");
    // Negative headroom on the battery rail, then the rail sags.
    wr(8'h00, 32'h18000);
    i_hrl_far_model.set_rails(12'hfff, 12'h500, 1'b0);
    send(16'h7000);
    chk(lim(32'h7000, 32'h6000), s, "track");
    rd(8'h10);
    chk(32'hf000500, d[29:0], "supply");
    i_hrl_far_model.set_rails(12'hfff, 12'h280, 1'b0);
    send(16'h7000);
    chk(lim(32'h7000, 32'h3000), s, "sag");
    wr(8'h00, 32'h0);
    i_hrl_far_model.set_rails(12'hfff, 12'h100, 1'b1);
    send(16'h7fff);
    chk(16'h7fff, s, "clamp");
    chk(1'b0, limiting, "flag");
    rd(8'h08);
    chk(16'h8000, d[15:0], "ratio");
    $display("mode one tests done");
  end
  endtask
  task t_mode2;
  begin
    for (n = 0; n < 16; n = n + 1)
    begin
      wr(8'h00, 32'h1 | (n << 8));
      // The gain table output is registered, so let it settle first.
      @(posedge clk_sys);
      rd(8'h0c);
      g = d[27:12];
      e = $rtoi(32768.0 * 10.0 ** (-n / 20.0) + 0.5);
      chk(e, ($unsigned(g - e + 1) <= 2) ? e : g, "gain");
      chk((32'h800 * g) >> 15, d[11:0], "vlimit");
      i_hrl_far_model.set_rails(n[0] ? 12'h200 : 12'hfff, 12'hfff, 1'b1);
      send(16'h7000);
      chk(lim(32'h7000, g), s, "level");
    end
    $display("mode two tests done");
  end
  endtask
  task t_stream;
  begin
    wr(8'h00, 32'h10);
    send(16'h7000);
    chk(16'h7000, s, "bypass");
    i_hrl_far_model.stall <= 1'b1;
    sample_in_valid <= 1'b1;
    sample_in <= 16'h0100;
    n = 0;
    for (i = 0; i < 60; i = i + 1)
    begin
      @(negedge clk_sys);
      r = sample_in_ready;
      @(posedge clk_sys);
      if (r)
        n = n + 1;
      sample_in <= 16'h0100 + n[15:0];
    end
    sample_in_valid <= 1'b0;
    chk(32'd17, n, "accepted");
    chk(1'b0, sample_in_ready, "full");
    i_hrl_far_model.stall <= 1'b0;
    for (i = 0; i < 17; i = i + 1)
    begin
      get;
      chk(16'h0100 + i[15:0], s, "order");
    end
    $display("stream tests done");
  end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'h04);
    chk(32'hfff, d, "mpo_rst");
    rd(8'h14);
    chk(32'h0, d, "unmapped");
    t_mode1;
    t_mode2;
    t_stream;
    complete_run;
  end
endmodule // tb_top
